/* core/mbx_defines.vh */
// constants for the modbus slave query checker and exception builder
// assumes inclusion by bare name from core design files
`ifndef MBX_DEFINES_VH
`define MBX_DEFINES_VH
// register byte offsets
`define MBX_REG_CTRL      12'h000
`define MBX_REG_RANGE     12'h004
`define MBX_REG_SCALE     12'h008
`define MBX_REG_STATUS    12'h00C
`define MBX_REG_STATION   12'h010
// control fields
`define MBX_CTRL_ASCII    0
`define MBX_CTRL_WREN     1
`define MBX_CTRL_FAMILY   2
`define MBX_CTRL_RST      32'h0000_0000
// range reset: low half lower bound 0, high half upper bound 32767
`define MBX_RANGE_RST     32'h7FFF_0000
`define MBX_SCALE_RST     32'h7FFF_0000
`define MBX_STATION_RST   8'h01
// exception codes
`define MBX_EX_NONE       8'h00
`define MBX_EX_FUNC       8'h01
`define MBX_EX_ADDR       8'h02
`define MBX_EX_DATA       8'h03
`define MBX_EX_BUSY       8'h06
// function codes
`define MBX_FC_RD_COIL    8'h01
`define MBX_FC_RD_INPUT   8'h02
`define MBX_FC_RD_HOLD    8'h03
`define MBX_FC_RD_INREG   8'h04
`define MBX_FC_WR_COIL    8'h05
`define MBX_FC_WR_REG     8'h06
`define MBX_FC_RD_EXC     8'h07
`define MBX_FC_LOOP       8'h08
`define MBX_FC_WR_COILS   8'h0F
`define MBX_FC_WR_REGS    8'h10
`define MBX_FC_EXC_BIT    8'h80
// alias windows, first family
`define MBX_A_DOUT_LO     17'd1
`define MBX_A_DOUT_HI     17'd2000
`define MBX_A_IINT_LO     17'd30001
`define MBX_A_IINT_HI     17'd31000
// alias windows, second family
`define MBX_A_RMEM_LO     17'd45000
`define MBX_A_RMEM_HI     17'd49999
`define MBX_A_RWIN_LO     17'd40000
`define MBX_A_RWIN_HI     17'd49999
`define MBX_DIGIT_UNIT    17'd10000
`endif

/* core/mbx_query_check.v */
// modbus slave query checker: checksum gate, alias decode, exception build
// assumes a framer upstream that delivers one parsed query per pulse
`timescale 1ns/1ns
`include "mbx_defines.vh"
module mbx_query_check (
	// clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// axi4-lite write address and data
	input  wire [11:0] s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read
	input  wire [11:0] s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// parsed query from the framer
	input  wire        q_valid,
	input  wire [7:0]  q_station,
	input  wire [7:0]  q_func,
	input  wire [16:0] q_alias,
	input  wire [15:0] q_count,
	input  wire signed [15:0] q_value,
	input  wire        q_chk_ok,
	// processor link
	input  wire        main_processor_ok,
	// point access request to the processors
	output reg         pt_req,
	output reg  [3:0]  pt_type,
	output reg  [13:0] pt_addr,
	output reg         pt_write,
	output reg  [15:0] pt_count,
	output reg  [31:0] pt_scaled,
	// exception reply, check field appended by the framer
	output reg         ex_valid,
	output reg  [7:0]  ex_station,
	output reg  [7:0]  ex_func,
	output reg  [7:0]  ex_code,
	output reg         ex_ascii,
	// activity indicator
	output reg         active
);

// =====================================================================
// register file
reg  [31:0] ctrl;
reg  [31:0] range_reg;
reg  [31:0] scale_reg;
reg  [7:0]  station;
reg  [7:0]  last_code;
reg  [15:0] drop_cnt;
reg  [11:0] aw_addr;
reg  [31:0] w_data;
reg  [3:0]  w_strb;
reg         aw_have;
reg         w_have;

function [31:0] merge;
	input [31:0] old;
	input [31:0] nw;
	input [3:0]  st;
	integer i;
	begin
		merge = old;
		for (i = 0; i < 4; i = i + 1) begin
			if (st[i])
				merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	end
endfunction

wire        do_write = aw_have && w_have && !s_axi_bvalid;
wire [11:0] wa = aw_addr;

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b0;
		s_axi_wready  <= 1'b0;
		s_axi_bvalid  <= 1'b0;
		s_axi_bresp   <= 2'b00;
		aw_have       <= 1'b0;
		w_have        <= 1'b0;
		aw_addr       <= 12'h000;
		w_data        <= 32'h0000_0000;
		w_strb        <= 4'h0;
		ctrl          <= `MBX_CTRL_RST;
		range_reg     <= `MBX_RANGE_RST;
		scale_reg     <= `MBX_SCALE_RST;
		station       <= `MBX_STATION_RST;
	end else begin
		s_axi_awready <= !aw_have && !s_axi_awready && s_axi_awvalid;
		s_axi_wready  <= !w_have && !s_axi_wready && s_axi_wvalid;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end
		if (do_write) begin
			aw_have      <= 1'b0;
			w_have       <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= 2'b00;
			case (wa)
			`MBX_REG_CTRL:    ctrl      <= merge(ctrl, w_data, w_strb);
			`MBX_REG_RANGE:   range_reg <= merge(range_reg, w_data, w_strb);
			`MBX_REG_SCALE:   scale_reg <= merge(scale_reg, w_data, w_strb);
			`MBX_REG_STATION: begin
				if (w_strb[0])
					station <= w_data[7:0];
			end
			`MBX_REG_STATUS: s_axi_bresp <= 2'b00;
			default: s_axi_bresp <= 2'b10;
			endcase
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid  <= 1'b0;
		s_axi_rdata   <= 32'h0000_0000;
		s_axi_rresp   <= 2'b00;
	end else begin
		s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= 2'b00;
			case (s_axi_araddr)
			`MBX_REG_CTRL:    s_axi_rdata <= ctrl;
			`MBX_REG_RANGE:   s_axi_rdata <= range_reg;
			`MBX_REG_SCALE:   s_axi_rdata <= scale_reg;
			`MBX_REG_STATION: s_axi_rdata <= {24'h00_0000, station};
			`MBX_REG_STATUS:  s_axi_rdata <= {drop_cnt, last_code, 6'h00,
				main_processor_ok, active};
			default: begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= 2'b10;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

// =====================================================================
// alias decode
wire        is_ascii  = ctrl[`MBX_CTRL_ASCII];
wire        wr_enable = ctrl[`MBX_CTRL_WREN];
wire        family2   = ctrl[`MBX_CTRL_FAMILY];

// splitting alias into top digit and remainder
function [3:0] alias_digit;
	input [16:0] a;
	begin
		if (a >= 17'd90000) alias_digit = 4'd9;
		else if (a >= 17'd80000) alias_digit = 4'd8;
		else if (a >= 17'd70000) alias_digit = 4'd7;
		else if (a >= 17'd60000) alias_digit = 4'd6;
		else if (a >= 17'd50000) alias_digit = 4'd5;
		else if (a >= 17'd40000) alias_digit = 4'd4;
		else if (a >= 17'd30000) alias_digit = 4'd3;
		else if (a >= 17'd20000) alias_digit = 4'd2;
		else if (a >= `MBX_DIGIT_UNIT) alias_digit = 4'd1;
		else alias_digit = 4'd0;
	end
endfunction

function in_win;
	input [16:0] a;
	input [16:0] lo;
	input [16:0] hi;
	begin
		in_win = (a >= lo) && (a <= hi);
	end
endfunction

wire [3:0]  digit   = alias_digit(q_alias);
wire [16:0] rem_w   = q_alias - digit * `MBX_DIGIT_UNIT;
wire [13:0] hw_addr = rem_w[13:0];

// only aliased windows map, except loopback (08) which passes any alias; anything else is unreachable from outside
wire a_dout = !family2 && in_win(q_alias, `MBX_A_DOUT_LO, `MBX_A_DOUT_HI);
wire a_iint = !family2 && in_win(q_alias, `MBX_A_IINT_LO, `MBX_A_IINT_HI);
wire a_rmem = family2 && in_win(q_alias, `MBX_A_RMEM_LO, `MBX_A_RMEM_HI)
	&& in_win(q_alias, `MBX_A_RWIN_LO, `MBX_A_RWIN_HI);
wire [16:0] end_alias = q_alias + q_count - 17'd1;
wire end_dout = in_win(end_alias, `MBX_A_DOUT_LO, `MBX_A_DOUT_HI);
wire end_iint = in_win(end_alias, `MBX_A_IINT_LO, `MBX_A_IINT_HI);
wire end_rmem = in_win(end_alias, `MBX_A_RMEM_LO, `MBX_A_RMEM_HI);

wire fc_coil  = q_func == `MBX_FC_RD_COIL || q_func == `MBX_FC_WR_COIL ||
	q_func == `MBX_FC_WR_COILS || q_func == `MBX_FC_RD_EXC;
wire fc_inreg = q_func == `MBX_FC_RD_INREG;
wire fc_hold  = q_func == `MBX_FC_RD_HOLD || q_func == `MBX_FC_WR_REG ||
	q_func == `MBX_FC_WR_REGS;
wire fc_write = q_func == `MBX_FC_WR_COIL || q_func == `MBX_FC_WR_REG ||
	q_func == `MBX_FC_WR_COILS || q_func == `MBX_FC_WR_REGS;
wire fc_known = fc_coil || fc_inreg || fc_hold || q_func == `MBX_FC_RD_INPUT ||
	q_func == `MBX_FC_LOOP;
wire fc_data  = q_func != `MBX_FC_LOOP;
wire addr_ok  = (fc_coil && a_dout && (q_count == 16'h0000 || end_dout)) ||
	(fc_inreg && a_iint && (q_count == 16'h0000 || end_iint)) ||
	(fc_hold && a_rmem && (q_count == 16'h0000 || end_rmem)) ||
	q_func == `MBX_FC_LOOP;
wire signed [15:0] lo_b = range_reg[15:0];
wire signed [15:0] hi_b = range_reg[31:16];
wire data_ok  = !(fc_hold && fc_write) || (q_value >= lo_b && q_value <= hi_b);

// exception priority: function, then address, then data, then link/write
reg [7:0] code_n;
always @* begin
	code_n = `MBX_EX_NONE;
	if (!fc_known)
		code_n = `MBX_EX_FUNC;
	else if (!addr_ok)
		code_n = `MBX_EX_ADDR;
	else if (!data_ok)
		code_n = `MBX_EX_DATA;
	else if (fc_data && !main_processor_ok)
		code_n = `MBX_EX_BUSY;
	else if (fc_write && !wr_enable)
		code_n = `MBX_EX_BUSY;
	// only 00 (none), 01, 02, 03 and 06 can come out of this chain
end

// linear scaling of real points: (v - lo) * span_out / span_in + min
wire signed [16:0] span_in  = {hi_b[15], hi_b} - {lo_b[15], lo_b};
wire signed [15:0] out_min  = scale_reg[15:0];
wire signed [15:0] out_max  = scale_reg[31:16];
wire signed [16:0] span_out = {out_max[15], out_max} - {out_min[15], out_min};
wire signed [16:0] v_off    = {q_value[15], q_value} - {lo_b[15], lo_b};
wire signed [33:0] prod     = v_off * span_out;
wire signed [33:0] quot     = (span_in == 17'sd0) ? 34'sd0 : prod / span_in;
wire signed [33:0] scaled   = quot + {{18{out_min[15]}}, out_min};

// =====================================================================
// query handling
always @(posedge aclk) begin
	if (!aresetn) begin
		pt_req     <= 1'b0;
		pt_type    <= 4'h0;
		pt_addr    <= 14'h0000;
		pt_write   <= 1'b0;
		pt_count   <= 16'h0000;
		pt_scaled  <= 32'h0000_0000;
		ex_valid   <= 1'b0;
		ex_station <= 8'h00;
		ex_func    <= 8'h00;
		ex_code    <= 8'h00;
		ex_ascii   <= 1'b0;
		active     <= 1'b1;
		last_code  <= 8'h00;
		drop_cnt   <= 16'h0000;
	end else begin
		pt_req   <= 1'b0;
		ex_valid <= 1'b0;
		if (main_processor_ok)
			active <= 1'b1;
		if (q_valid && !q_chk_ok) begin
			// checksum kind (crc or lrc) is chosen by the framer per mode
			drop_cnt <= drop_cnt + 16'h0001;
		end else if (q_valid && q_station == station) begin
			if (code_n != `MBX_EX_NONE) begin
				ex_valid   <= 1'b1;
				ex_station <= station;
				ex_func    <= q_func | `MBX_FC_EXC_BIT;
				ex_code    <= code_n;
				ex_ascii   <= is_ascii;
				last_code  <= code_n;
				if (fc_data && !main_processor_ok)
					active <= 1'b0;
			end else begin
				pt_req    <= 1'b1;
				pt_type   <= digit;
				pt_addr   <= hw_addr;
				pt_write  <= fc_write;
				pt_count  <= q_count;
				pt_scaled <= a_rmem ? scaled[31:0] : {{16{q_value[15]}}, q_value};
			end
		end
		// a bad frame never reaches the branch above, so no reply
	end
end

endmodule

/* verif/mbx_assertions.sv */
// port-level checker for the modbus query checker
// assumes a bind onto mbx_query_check from the bench top
`timescale 1ns/1ns
module mbx_assertions (
	// clock and reset
	input wire        aclk,
	input wire        aresetn,
	// query side
	input wire        q_valid,
	input wire [7:0]  q_station,
	input wire [7:0]  q_func,
	input wire [16:0] q_alias,
	input wire        q_chk_ok,
	input wire        main_processor_ok,
	// answers
	input wire        pt_req,
	input wire [3:0]  pt_type,
	input wire [13:0] pt_addr,
	input wire        ex_valid,
	input wire [7:0]  ex_station,
	input wire [7:0]  ex_func,
	input wire [7:0]  ex_code,
	input wire        active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// ========================================
	// checks
	a_bad_frame_drop: assert property (q_valid && !q_chk_ok |=> !ex_valid && !pt_req)
		else $error("bad frame answered");
	a_answer_cause: assert property (ex_valid || pt_req |-> $past(q_valid && q_chk_ok))
		else $error("answer without checked query");
	a_ex_echo: assert property (q_valid && q_chk_ok ##1 ex_valid |->
		ex_func == ($past(q_func) | 8'h80) && ex_station == $past(q_station))
		else $error("exception header wrong");
	a_code_legal: assert property (ex_valid |-> ex_code inside {8'h01, 8'h02, 8'h03, 8'h06})
		else $error("exception code out of set");
	a_func_illegal: assert property (q_valid && q_chk_ok &&
		!(q_func inside {[8'h01:8'h08], 8'h0F, 8'h10}) |=> !pt_req && (!ex_valid || ex_code == 8'h01))
		else $error("unknown function not refused");
	a_proc_down: assert property (q_valid && q_chk_ok && !main_processor_ok && q_func != 8'h08
		|=> !pt_req) else $error("access while processors down");
	a_active_off: assert property (ex_valid && ex_code == 8'h06 && !$past(main_processor_ok)
		|-> ##[0:1] !active) else $error("indicator left on");
	a_alias_split: assert property (pt_req |-> pt_type == 4'($past(q_alias) / 17'd10000) &&
		pt_addr == 14'($past(q_alias) % 17'd10000)) else $error("alias split wrong");
	cover property (ex_valid && ex_code == 8'h06);
	cover property (pt_req);
	cover property (q_valid && !q_chk_ok);
endmodule

/* verif/mbx_master_model.sv */
// modbus master model: hands whole parsed queries to the checker
// assumes send is called right after a rising edge of aclk
`timescale 1ns/1ns
module mbx_master_model (
	// clock
	input wire          aclk,
	// parsed query
	output logic        q_valid,
	output logic [7:0]  q_station,
	output logic [7:0]  q_func,
	output logic [16:0] q_alias,
	output logic [15:0] q_count,
	output logic [15:0] q_value,
	output logic        q_chk_ok
);
	initial begin
		{q_valid, q_station, q_func, q_alias, q_count, q_value, q_chk_ok} = '0;
	end
	// ========================================
	// one query; fields other than q_count are scrambled afterwards so nothing relies on stale values
	task send(input [7:0] st, input [7:0] f, input [16:0] al, input [15:0] n, input [15:0] v,
		input ok);
		q_valid <= 1'b1;
		q_station <= st;
		q_func <= f;
		q_alias <= al;
		q_count <= n;
		q_value <= v;
		q_chk_ok <= ok;
		@(posedge aclk);
		q_valid <= 1'b0;
		{q_station, q_func, q_alias, q_value, q_chk_ok} <= ~{st, f, al, v, ok};
	endtask
endmodule

/* verif/tb.sv */
// self-checking bench for mbx_query_check
// assumes the master model and checker files compile first
`timescale 1ns/1ns
module tb;
	logic        aclk, aresetn, main_processor_ok;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0]   s_axi_bresp, s_axi_rresp;
	wire [31:0]  s_axi_rdata, pt_scaled;
	wire         q_valid, q_chk_ok, pt_req, pt_write, ex_valid, ex_ascii, active;
	wire [7:0]   q_station, q_func, ex_station, ex_func, ex_code;
	wire [16:0]  q_alias;
	wire [15:0]  q_count, q_value, pt_count;
	wire [3:0]   pt_type;
	wire [13:0]  pt_addr;
	int          miscompares = 0;
	int          checked = 0;
	mbx_query_check i_mbx_query_check (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .q_valid, .q_station, .q_func, .q_alias,
		.q_count, .q_value, .q_chk_ok, .main_processor_ok, .pt_req, .pt_type, .pt_addr,
		.pt_write, .pt_count, .pt_scaled, .ex_valid, .ex_station, .ex_func, .ex_code,
		.ex_ascii, .active);
	mbx_master_model i_mbx_master_model (.aclk, .q_valid, .q_station, .q_func, .q_alias,
		.q_count, .q_value, .q_chk_ok);
	// ========================================
	// helpers
	task chk(input string what, input [31:0] exp, input [31:0] got);
		checked++;
		if (exp !== got) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task end_of_test;
		if (miscompares == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task wr(input [11:0] a, input [31:0] d, input [1:0] er);
		logic pa, pw, pb;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		{pa, pw, pb} = 3'b111;
		for (int n = 0; n < 40 && pb; n++) begin
			@(posedge aclk);
			if (pa && s_axi_awready) begin
				pa = 0;
				s_axi_awvalid <= 0;
			end
			if (pw && s_axi_wready) begin
				pw = 0;
				s_axi_wvalid <= 0;
			end
			if (s_axi_bvalid) begin
				pb = 0;
				s_axi_bready <= 0;
				chk("bresp", er, s_axi_bresp);
			end
		end
		if (pb) begin
			chk("bvalid", 1, 0);
			end_of_test;
		end
	endtask
	task rd(input [11:0] a, input [31:0] ed, input [1:0] er);
		logic pa, pr;
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		{pa, pr} = 2'b11;
		for (int n = 0; n < 40 && pr; n++) begin
			@(posedge aclk);
			if (pa && s_axi_arready) begin
				pa = 0;
				s_axi_arvalid <= 0;
			end
			if (s_axi_rvalid) begin
				pr = 0;
				s_axi_rready <= 0;
				chk("rdata", ed, s_axi_rdata);
				chk("rresp", er, s_axi_rresp);
			end
		end
		if (pr) begin
			chk("rvalid", 1, 0);
			end_of_test;
		end
	endtask
	// e: 8'hFF access expected, 8'h00 silence, else exception code
	task qn(input [7:0] f, input [16:0] al, input [15:0] n, input [15:0] v, input ok,
		input [7:0] e);
		@(posedge aclk);
		i_mbx_master_model.send(8'h01, f, al, n, v, ok);
		#1;
		chk("pt_req", e == 8'hFF, pt_req);
		chk("ex_valid", e != 8'hFF && e != 8'h00, ex_valid);
		if (e == 8'hFF) begin
			chk("pt_type", al / 17'd10000, pt_type);
			chk("pt_addr", al % 17'd10000, pt_addr);
			chk("pt_write", f inside {8'h05, 8'h06, 8'h0F, 8'h10}, pt_write);
			chk("pt_count", n, pt_count);
		end
		if (e != 8'hFF && e != 8'h00) begin
			chk("ex_code", e, ex_code);
			chk("ex_func", f | 8'h80, ex_func);
			chk("ex_station", 8'h01, ex_station);
		end
	endtask
	task qy(input [7:0] f, input [16:0] al, input [15:0] v, input ok, input [7:0] e);
		qn(f, al, 16'h0001, v, ok, e);
	endtask
	// ========================================
	// stimulus
	initial begin
		aclk = 0;
		forever #5 aclk = ~aclk;
	end
	initial begin
		{aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		s_axi_wstrb = 4'hF;
		main_processor_ok = 1;
		repeat (12) @(posedge aclk);
		aresetn <= 1;
		rd(12'h000, 32'h0000_0000, 2'b00);
		rd(12'h004, 32'h7FFF_0000, 2'b00);
		rd(12'h008, 32'h7FFF_0000, 2'b00);
		rd(12'h010, 32'h0000_0001, 2'b00);
		rd(12'h0FC, 32'h0000_0000, 2'b10);
		wr(12'h0FC, 32'h0000_0001, 2'b10);
		qy(8'h01, 17'd2000, 0, 1, 8'hFF);
		chk("pt_scaled", 32'h0000_0000, pt_scaled);
		qy(8'h01, 17'd2001, 0, 1, 8'h02);
		chk("ex_ascii", 0, ex_ascii);
		qn(8'h01, 17'd1999, 16'h0002, 0, 1, 8'hFF);
		qn(8'h01, 17'd1999, 16'h0003, 0, 1, 8'h02);
		qy(8'h04, 17'd30001, 0, 1, 8'hFF);
		qy(8'h04, 17'd31001, 0, 1, 8'h02);
		qn(8'h04, 17'd31000, 16'h0002, 0, 1, 8'h02);
		qy(8'h02, 17'd10001, 0, 1, 8'h02);
		qy(8'h11, 17'd1, 0, 1, 8'h01);
		qy(8'h07, 17'd1, 0, 1, 8'hFF);
		qy(8'h08, 17'd0, 0, 1, 8'hFF);
		qy(8'h01, 17'd1, 0, 0, 8'h00);
		qy(8'h01, 17'd1, 0, 1, 8'hFF);
		qy(8'h05, 17'd1, 0, 1, 8'h06);
		qy(8'h0F, 17'd1, 0, 1, 8'h06);
		wr(12'h010, 32'h0000_0022, 2'b00);
		qy(8'h01, 17'd1, 0, 1, 8'h00);
		wr(12'h010, 32'h0000_0001, 2'b00);
		wr(12'h000, 32'h0000_0003, 2'b00);
		qy(8'h05, 17'd1, 16'hFF00, 1, 8'hFF);
		chk("pt_scaled", 32'hFFFF_FF00, pt_scaled);
		qy(8'h05, 17'd2001, 0, 1, 8'h02);
		chk("ex_ascii", 1, ex_ascii);
		wr(12'h000, 32'h0000_0004, 2'b00);
		qy(8'h06, 17'd45000, 0, 1, 8'h06);
		qy(8'h10, 17'd45000, 0, 1, 8'h06);
		qy(8'h03, 17'd49999, 0, 1, 8'hFF);
		qy(8'h03, 17'd44999, 0, 1, 8'h02);
		wr(12'h000, 32'h0000_0006, 2'b00);
		wr(12'h004, 32'h0064_FFFB, 2'b00);
		s_axi_wstrb <= 4'h3;
		wr(12'h004, 32'hAAAA_FFFB, 2'b00);
		s_axi_wstrb <= 4'hF;
		rd(12'h004, 32'h0064_FFFB, 2'b00);
		qy(8'h06, 17'd45000, 16'h0064, 1, 8'hFF);
		chk("pt_scaled", 32'h0000_7FFF, pt_scaled);
		qy(8'h06, 17'd45000, 16'h0065, 1, 8'h03);
		qy(8'h10, 17'd45000, 16'hFFFB, 1, 8'hFF);
		chk("pt_scaled", 32'h0000_0000, pt_scaled);
		qy(8'h10, 17'd45000, 16'hFFFA, 1, 8'h03);
		wr(12'h008, 32'h0064_FF9C, 2'b00);
		qy(8'h10, 17'd45000, 16'hFFFB, 1, 8'hFF);
		chk("pt_scaled", 32'hFFFF_FF9C, pt_scaled);
		wr(12'h004, 32'h7FFF_8000, 2'b00);
		qy(8'h06, 17'd45000, 16'h8000, 1, 8'hFF);
		qy(8'h06, 17'd49999, 16'h7FFF, 1, 8'hFF);
		chk("pt_scaled", 32'h0000_0064, pt_scaled);
		@(posedge aclk);
		main_processor_ok <= 0;
		qy(8'h03, 17'd45000, 0, 1, 8'h06);
		chk("active", 0, active);
		qy(8'h08, 17'd0, 0, 1, 8'hFF);
		rd(12'h00C, 32'h0001_0600, 2'b00);
		main_processor_ok <= 1;
		repeat (2) @(posedge aclk);
		chk("active", 1, active);
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(12'h00C, 32'h0000_0003, 2'b00);
		rd(12'h004, 32'h7FFF_0000, 2'b00);
		end_of_test;
	end
endmodule
bind mbx_query_check mbx_assertions i_mbx_assertions (.aclk, .aresetn, .q_valid, .q_station,
	.q_func, .q_alias, .q_chk_ok, .main_processor_ok, .pt_req, .pt_type, .pt_addr, .ex_valid,
	.ex_station, .ex_func, .ex_code, .active);
